// ---- common/swl_params.svh ----
// constants for the write latch and register command block
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

// opcodes
`define SWL_OP_SET_WRITE_LATCH   8'h06
`define SWL_OP_CLEAR_WRITE_LATCH 8'h04
`define SWL_OP_STATUS_WRITE      8'h01
`define SWL_OP_STATUS_ONE_READ   8'h05
`define SWL_OP_STATUS_TWO_READ   8'h07
`define SWL_OP_CONFIG_ONE_READ   8'h35
`define SWL_OP_CONFIG_TWO_READ   8'h3F
`define SWL_OP_CONFIG_FOUR_READ  8'h45
`define SWL_OP_CONFIG_FIVE_READ  8'h5E
`define SWL_OP_GENERIC_WRITE     8'h71
`define SWL_OP_GENERIC_READ      8'h65
`define SWL_OP_DEEP_POWERDOWN    8'hB9
`define SWL_OP_HIBERNATE         8'hBA
`define SWL_OP_RESET_ARM         8'h66
`define SWL_OP_RESET             8'h99
// write-type memory opcodes that need the latch
`define SWL_OP_MEM_WRITE         8'h02
`define SWL_OP_MEM_FAST_WRITE    8'hDA
`define SWL_OP_MEM_DIW           8'hA2
`define SWL_OP_MEM_DIOW          8'hA1
`define SWL_OP_MEM_QIW           8'h32
`define SWL_OP_MEM_QIOW          8'hD2
`define SWL_OP_MEM_DDR_FAST      8'hDD
`define SWL_OP_MEM_DDR_WRITE     8'hDE
`define SWL_OP_MEM_DDR_QIOW      8'hD1
`define SWL_OP_SPECIAL_SECT_WR   8'h42
`define SWL_OP_SERIAL_NUM_WR     8'hC2

// generic register address: upper 16 bits select volatile or nonvolatile copy
`define SWL_RA_VOL_HI            16'h0700
`define SWL_RA_NV_HI             16'h0000
`define SWL_RA_SR1               8'h00
`define SWL_RA_SR2               8'h01
`define SWL_RA_CR1               8'h02
`define SWL_RA_CR2               8'h03
`define SWL_RA_CR4               8'h05
`define SWL_RA_CR5               8'h06

// register index codes
`define SWL_IDX_SR1              3'h0
`define SWL_IDX_SR2              3'h1
`define SWL_IDX_CR1              3'h2
`define SWL_IDX_CR2              3'h3
`define SWL_IDX_CR4              3'h4
`define SWL_IDX_CR5              3'h5
`define SWL_IDX_NONE             3'h7

// status register one fields
`define SWL_SR1_WRITE_DISABLE    7
`define SWL_SR1_WEL              1
`define SWL_SR1_WIP              0
// writable bits per register
`define SWL_SR1_WMASK            8'h9C
`define SWL_CR1_WMASK            8'hFF
`define SWL_CR2_WMASK            8'hFF
`define SWL_CR4_WMASK            8'hFF
`define SWL_CR5_WMASK            8'h03
// bits backed by nonvolatile storage, the rest take defaults on reset
`define SWL_SR1_NV_MASK          8'h9C
`define SWL_SR1_DEFAULT          8'h00
// register latency code position in config register five
`define SWL_CR5_RLC_LO           0
`define SWL_CR5_RLC_HI           1

// lane modes
`define SWL_LANES_ONE            2'h0
`define SWL_LANES_TWO            2'h1
`define SWL_LANES_FOUR           2'h2

`define SWL_ADDR_BYTES           2'h3
`define SWL_SYNC_W               6

`endif

// ---- common/swl_pkg.sv ----
// types for the write latch and register command block
package swl_pkg;

	typedef enum logic [6:0] {
		SWL_IDLE  = 7'b0000001,
		SWL_OPC   = 7'b0000010,
		SWL_ADDR  = 7'b0000100,
		SWL_DUMMY = 7'b0001000,
		SWL_RDATA = 7'b0010000,
		SWL_WDATA = 7'b0100000,
		SWL_SKIP  = 7'b1000000
	} swl_state_e;

	typedef logic [7:0] swl_byte_t;

endpackage

// ---- dv/swl_cmd_assertions.sv ----
// port assertions for the write latch command block
`include "swl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swl_cmd_chk (
	input wire logic       mclk_i,
	input wire logic       resetn_i,
	input wire logic       cs_n_i,
	input wire logic       write_protect_n_i,
	input wire logic       write_in_progress_i,
	input wire logic [3:0] io_oe_o,
	input wire logic       write_enable_latch_o,
	input wire logic [7:0] status_reg_one_o,
	input wire logic       nv_write_o,
	input wire logic [2:0] nv_index_o,
	input wire logic       mem_write_grant_o,
	input wire logic       deep_powerdown_o,
	input wire logic       soft_reset_o,
	input wire logic [7:0] config_reg_five_o,
	input wire logic [7:0] nv_config_reg_five_i
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	sequence cs_idle_s; cs_n_i [*8]; endsequence
	sequence pulse_gone_s; !deep_powerdown_o && !soft_reset_o; endsequence
	latch_at_cs_a: assert property ($changed(write_enable_latch_o) |-> cs_n_i && $past(cs_n_i, 2))
		else $error("latch moved while selected");
	status_mirror_a: assert property (status_reg_one_o[1:0] == {$past(write_enable_latch_o), $past(write_in_progress_i)})
		else $error("status low bits do not follow latch and busy");
	ro_bits_a: assert property (status_reg_one_o[6:5] == 2'b00)
		else $error("read only status bits set");
	grant_latch_a: assert property (mem_write_grant_o |-> write_enable_latch_o)
		else $error("memory write granted without latch");
	status_write_cmd_clear_a: assert property (nv_write_o && nv_index_o == `SWL_IDX_SR1 |-> ##[0:3] !write_enable_latch_o)
		else $error("latch kept after status write");
	protect_a: assert property (nv_write_o && nv_index_o == `SWL_IDX_SR1 |-> write_protect_n_i || !$past(status_reg_one_o[7]))
		else $error("status write despite protection");
	oe_release_a: assert property (cs_idle_s |=> io_oe_o == 4'h0)
		else $error("lanes driven while deselected");
	pulse_one_a: assert property (deep_powerdown_o || soft_reset_o |-> cs_n_i ##1 pulse_gone_s)
		else $error("power pulse not single or not after frame");
	reload_a: assert property (soft_reset_o |-> ##[0:4] config_reg_five_o == nv_config_reg_five_i)
		else $error("soft reset did not reload config five");
endmodule // swl_cmd_chk

bind swl_cmd swl_cmd_chk chk_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
	.write_protect_n_i(write_protect_n_i), .write_in_progress_i(write_in_progress_i), .io_oe_o(io_oe_o),
	.write_enable_latch_o(write_enable_latch_o), .status_reg_one_o(status_reg_one_o), .nv_write_o(nv_write_o),
	.nv_index_o(nv_index_o), .mem_write_grant_o(mem_write_grant_o), .deep_powerdown_o(deep_powerdown_o),
	.soft_reset_o(soft_reset_o), .config_reg_five_o(config_reg_five_o), .nv_config_reg_five_i(nv_config_reg_five_i));
`default_nettype wire

// ---- dv/swl_host_model.sv ----
// host serial master model, mode 0, one lane
`timescale 1ns/1ps
`default_nettype none

module swl_host_model #(
	parameter int HALF = 4
) (
	input  wire logic       mclk_i,
	input  wire logic [3:0] dev_io_i,
	output logic            cs_n_o,
	output logic            sck_o,
	output logic      [3:0] lanes_o
);
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		lanes_o = 4'hF;
	end
	// sends ntx bits msb first, nd dummy clocks, then reads nrx bits
	task automatic frame(input logic [39:0] tx, input int ntx, input int nd, input int nrx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		@(posedge mclk_i) cs_n_o <= 1'b0;
		for (i = 0; i < ntx + nd + nrx; i++) begin
			@(posedge mclk_i);
			sck_o <= 1'b0;
			lanes_o[0] <= (i < ntx) ? tx[39 - i] : ~lanes_o[0];
			repeat (HALF) @(posedge mclk_i);
			sck_o <= 1'b1;
			repeat (HALF - 1) @(posedge mclk_i);
			@(negedge mclk_i);
			if (i >= ntx + nd) rx = {rx[6:0], dev_io_i[1]};
		end
		@(posedge mclk_i) sck_o <= 1'b0;
		repeat (HALF) @(posedge mclk_i);
		cs_n_o <= 1'b1;
		lanes_o[0] <= ~lanes_o[0];
		repeat (12) @(posedge mclk_i);
	endtask
endmodule // swl_host_model
`default_nettype wire

// ---- dv/test_swl_cmd.sv ----
// self-checking bench for the write latch command block
`include "swl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_swl_cmd;
	localparam logic [7:0] NV_SR1 = 8'h5D;
	localparam logic [7:0] SR2 = 8'hA5;
	localparam logic [7:0] CR1 = 8'h3C;
	localparam logic [7:0] CR2 = 8'h81;
	localparam logic [7:0] CR4 = 8'h42;
	typedef struct {logic [7:0] op; logic [7:0] exp;} swl_row_s;
	swl_row_s   rows [6] = '{'{`SWL_OP_STATUS_ONE_READ, NV_SR1 & `SWL_SR1_NV_MASK}, '{`SWL_OP_STATUS_TWO_READ, SR2},
		'{`SWL_OP_CONFIG_ONE_READ, CR1}, '{`SWL_OP_CONFIG_TWO_READ, CR2}, '{`SWL_OP_CONFIG_FOUR_READ, CR4},
		'{`SWL_OP_CONFIG_FIVE_READ, 8'h00}};
	logic [7:0] pwr [4] = '{`SWL_OP_DEEP_POWERDOWN, `SWL_OP_HIBERNATE, `SWL_OP_RESET_ARM, `SWL_OP_RESET};
	logic       mclk_i = 1'b0;
	logic       resetn_i = 1'b0;
	logic       write_protect_n_i = 1'b1;
	logic       write_in_progress_i = 1'b0;
	logic [1:0] lane_mode_i = `SWL_LANES_ONE;
	logic [7:0] status_reg_two_i = SR2;
	logic [7:0] nv_status_reg_one_i = NV_SR1;
	logic [7:0] nv_config_reg_one_i = CR1;
	logic [7:0] nv_config_reg_two_i = CR2;
	logic [7:0] nv_config_reg_four_i = CR4;
	logic [7:0] nv_config_reg_five_i = 8'h00;
	logic       cs_n_i, sck_i, nv_write_o, write_enable_latch_o, mem_write_grant_o;
	logic       deep_powerdown_o, hibernate_o, reset_arm_o, soft_reset_o;
	logic [3:0] io_i, io_o, io_oe_o;
	logic [2:0] nv_index_o;
	logic [7:0] nv_data_o, status_reg_one_o, config_reg_one_o, config_reg_two_o, config_reg_four_o;
	logic [7:0] config_reg_five_o, rxb;
	int         err_count = 0;
	int         samples_checked = 0;
	int         cnt [6] = '{default: 0};
	logic [5:0] pulses;

	assign pulses = {soft_reset_o, reset_arm_o, hibernate_o, deep_powerdown_o, mem_write_grant_o, nv_write_o};
	always #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		foreach (cnt[k]) cnt[k] <= cnt[k] + int'(pulses[k]);
		if (nv_write_o && nv_index_o == `SWL_IDX_SR1) nv_status_reg_one_i <= nv_data_o;
	end

	swl_cmd dut_u (.*);
	swl_host_model host_u (.mclk_i(mclk_i), .dev_io_i(io_o), .cs_n_o(cs_n_i), .sck_o(sck_i), .lanes_o(io_i));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic op(input logic [7:0] c);
		host_u.frame({c, 32'h0}, 8, 0, 0, rxb);
	endtask
	task automatic report_and_stop;
		if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk_i);
		err_count++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk(status_reg_one_o, NV_SR1 & `SWL_SR1_NV_MASK, "sr1 after reset");
		chk({7'h0, write_enable_latch_o}, 8'h00, "latch after reset");
		foreach (rows[k]) begin
			host_u.frame({rows[k].op, 32'h0}, 8, 0, 8, rxb);
			chk(rxb, rows[k].exp, "register read");
		end
		op(`SWL_OP_SET_WRITE_LATCH);
		chk({7'h0, write_enable_latch_o}, 8'h01, "set latch");
		write_in_progress_i <= 1'b1;
		op(`SWL_OP_CLEAR_WRITE_LATCH);
		chk({7'h0, write_enable_latch_o}, 8'h01, "clear while busy");
		write_in_progress_i <= 1'b0;
		op(`SWL_OP_CLEAR_WRITE_LATCH);
		chk({7'h0, write_enable_latch_o}, 8'h00, "clear latch");
		host_u.frame({`SWL_OP_STATUS_WRITE, 8'hFF, 24'h0}, 16, 0, 0, rxb);
		chk(status_reg_one_o, NV_SR1 & `SWL_SR1_NV_MASK, "status write no latch");
		op(`SWL_OP_SET_WRITE_LATCH);
		host_u.frame({`SWL_OP_STATUS_WRITE, 8'hFF, 24'h0}, 16, 0, 0, rxb);
		chk(status_reg_one_o, `SWL_SR1_WMASK, "status write");
		chk({7'h0, write_enable_latch_o}, 8'h00, "latch after status write");
		chk(8'(cnt[0]), 8'h01, "nonvolatile program");
		write_protect_n_i <= 1'b0;
		op(`SWL_OP_SET_WRITE_LATCH);
		host_u.frame({`SWL_OP_STATUS_WRITE, 32'h0}, 16, 0, 0, rxb);
		chk(status_reg_one_o, `SWL_SR1_WMASK, "protected status write");
		write_protect_n_i <= 1'b1;
		op(`SWL_OP_SET_WRITE_LATCH);
		host_u.frame({`SWL_OP_STATUS_WRITE, 32'h0}, 16, 0, 0, rxb);
		chk(status_reg_one_o, 8'h00, "unprotected status write");
		op(`SWL_OP_MEM_WRITE);
		chk(8'(cnt[1]), 8'h00, "grant without latch");
		op(`SWL_OP_SET_WRITE_LATCH);
		op(`SWL_OP_MEM_WRITE);
		chk(8'(cnt[1]), 8'h01, "grant with latch");
		op(`SWL_OP_SET_WRITE_LATCH);
		host_u.frame({`SWL_OP_GENERIC_WRITE, `SWL_RA_VOL_HI, `SWL_RA_CR5, 8'h02}, 40, 0, 0, rxb);
		chk(config_reg_five_o, 8'h02, "generic write");
		host_u.frame({`SWL_OP_CONFIG_FIVE_READ, 32'h0}, 8, 2, 8, rxb);
		chk(rxb, 8'h02, "read after two dummies");
		host_u.frame({`SWL_OP_GENERIC_READ, `SWL_RA_VOL_HI, `SWL_RA_CR5, 8'h0}, 32, 2, 8, rxb);
		chk(rxb, 8'h02, "generic read");
		host_u.frame({`SWL_OP_GENERIC_WRITE, `SWL_RA_VOL_HI, `SWL_RA_CR5, 8'h03}, 40, 0, 0, rxb);
		chk(config_reg_five_o, 8'h02, "generic write no latch");
		nv_config_reg_five_i <= 8'h01;
		foreach (pwr[k]) op(pwr[k]);
		foreach (pwr[k]) chk(8'(cnt[2 + k]), 8'h01, "power command");
		chk(config_reg_five_o, 8'h01, "soft reset reload");
		resetn_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		chk(status_reg_one_o, 8'h00, "sr1 restored");
		report_and_stop;
	end
endmodule // test_swl_cmd
`default_nettype wire

// ---- hdl/swl_cmd.sv ----
// serial command interpreter for write latch and register access
`include "swl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module swl_cmd
	import swl_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic [3:0] io_i,
	output logic      [3:0] io_o,
	output logic      [3:0] io_oe_o,
	input  wire logic       write_protect_n_i,
	input  wire logic [1:0] lane_mode_i,
	input  wire logic       write_in_progress_i,
	input  wire logic [7:0] status_reg_two_i,
	input  wire logic [7:0] nv_status_reg_one_i,
	input  wire logic [7:0] nv_config_reg_one_i,
	input  wire logic [7:0] nv_config_reg_two_i,
	input  wire logic [7:0] nv_config_reg_four_i,
	input  wire logic [7:0] nv_config_reg_five_i,
	output logic            nv_write_o,
	output logic      [2:0] nv_index_o,
	output logic      [7:0] nv_data_o,
	output logic            write_enable_latch_o,
	output logic      [7:0] status_reg_one_o,
	output logic      [7:0] config_reg_one_o,
	output logic      [7:0] config_reg_two_o,
	output logic      [7:0] config_reg_four_o,
	output logic      [7:0] config_reg_five_o,
	output logic            mem_write_grant_o,
	output logic            deep_powerdown_o,
	output logic            hibernate_o,
	output logic            reset_arm_o,
	output logic            soft_reset_o
);

	function automatic logic [3:0] lane_bits(input logic [1:0] m);
		case (m)
			`SWL_LANES_TWO:  lane_bits = 4'h2;
			`SWL_LANES_FOUR: lane_bits = 4'h4;
			default:         lane_bits = 4'h1;
		endcase
	endfunction

	function automatic swl_byte_t shift_in(input swl_byte_t sr, input logic [3:0] io, input logic [1:0] m);
		case (m)
			`SWL_LANES_TWO:  shift_in = {sr[5:0], io[1:0]};
			`SWL_LANES_FOUR: shift_in = {sr[3:0], io[3:0]};
			default:         shift_in = {sr[6:0], io[0]};
		endcase
	endfunction

	function automatic logic [2:0] addr_index(input logic [7:0] lo);
		case (lo)
			`SWL_RA_SR1: addr_index = `SWL_IDX_SR1;
			`SWL_RA_SR2: addr_index = `SWL_IDX_SR2;
			`SWL_RA_CR1: addr_index = `SWL_IDX_CR1;
			`SWL_RA_CR2: addr_index = `SWL_IDX_CR2;
			`SWL_RA_CR4: addr_index = `SWL_IDX_CR4;
			`SWL_RA_CR5: addr_index = `SWL_IDX_CR5;
			default:     addr_index = `SWL_IDX_NONE;
		endcase
	endfunction

	function automatic swl_byte_t merge(input swl_byte_t old, input swl_byte_t nw, input swl_byte_t m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// synchronised link pins
	wire  [5:0] lvl_w;
	wire  [5:0] rise_w;
	wire  [5:0] fall_w;

	swl_sync #(
		.W    (`SWL_SYNC_W),
		.INIT (6'h21)
	) u_sync (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.async_i  ({cs_n_i, sck_i, io_i}),
		.level_o  (lvl_w),
		.rise_o   (rise_w),
		.fall_o   (fall_w)
	);

	wire        cs_act_w  = ~lvl_w[5];
	wire        cs_rise_w = rise_w[5];
	wire        sck_rise_w = rise_w[4] & cs_act_w;
	wire        sck_fall_w = fall_w[4] & cs_act_w;
	wire  [3:0] io_s_w    = lvl_w[3:0];

	localparam swl_byte_t SR1_DEF = `SWL_SR1_DEFAULT;

	swl_state_e state_r;
	swl_byte_t  in_sr_r;
	swl_byte_t  out_sr_r;
	swl_byte_t  opcode_r;
	swl_byte_t  wdata_r;
	logic [23:0] addr_r;
	logic [3:0] bitcnt_r;
	logic [3:0] obitcnt_r;
	logic [1:0] abytes_r;
	logic [1:0] dcnt_r;
	logic       op_done_r;
	logic       wdata_ok_r;
	logic       extra_r;
	logic       armed_r;
	logic       sr1_wd_r;
	logic [7:2] sr1_r;

	wire  [3:0] nb_w       = lane_bits(lane_mode_i);
	wire        byte_w     = (bitcnt_r + nb_w) == 4'h8;
	wire  swl_byte_t in_nxt_w = shift_in(in_sr_r, io_s_w, lane_mode_i);
	wire  [1:0] rlc_w      = {config_reg_five_o[`SWL_CR5_RLC_HI], config_reg_five_o[`SWL_CR5_RLC_LO]};

	// opcode decode of the byte just completed
	wire        d_sr1_rd   = in_nxt_w == `SWL_OP_STATUS_ONE_READ;
	wire        d_sr2_rd   = in_nxt_w == `SWL_OP_STATUS_TWO_READ;
	wire        d_cr1_rd   = in_nxt_w == `SWL_OP_CONFIG_ONE_READ;
	wire        d_cr2_rd   = in_nxt_w == `SWL_OP_CONFIG_TWO_READ;
	wire        d_cr4_rd   = in_nxt_w == `SWL_OP_CONFIG_FOUR_READ;
	wire        d_cr5_rd   = in_nxt_w == `SWL_OP_CONFIG_FIVE_READ;
	wire        d_fix_rd   = d_sr1_rd | d_sr2_rd | d_cr1_rd | d_cr2_rd | d_cr4_rd | d_cr5_rd;
	wire        d_gen      = (in_nxt_w == `SWL_OP_GENERIC_WRITE) | (in_nxt_w == `SWL_OP_GENERIC_READ);
	wire        d_memwr    = (in_nxt_w == `SWL_OP_MEM_WRITE) | (in_nxt_w == `SWL_OP_MEM_FAST_WRITE)
	                       | (in_nxt_w == `SWL_OP_MEM_DIW) | (in_nxt_w == `SWL_OP_MEM_DIOW)
	                       | (in_nxt_w == `SWL_OP_MEM_QIW) | (in_nxt_w == `SWL_OP_MEM_QIOW)
	                       | (in_nxt_w == `SWL_OP_MEM_DDR_FAST) | (in_nxt_w == `SWL_OP_MEM_DDR_WRITE)
	                       | (in_nxt_w == `SWL_OP_MEM_DDR_QIOW) | (in_nxt_w == `SWL_OP_SPECIAL_SECT_WR)
	                       | (in_nxt_w == `SWL_OP_SERIAL_NUM_WR);
	wire  [2:0] fix_idx_w  = d_sr1_rd ? `SWL_IDX_SR1 : d_sr2_rd ? `SWL_IDX_SR2 : d_cr1_rd ? `SWL_IDX_CR1 :
	                         d_cr2_rd ? `SWL_IDX_CR2 : d_cr4_rd ? `SWL_IDX_CR4 : `SWL_IDX_CR5;

	// generic address decode on the last address byte
	wire  [23:0] addr_nxt_w = {addr_r[15:0], in_nxt_w};
	wire        a_vol_w    = addr_nxt_w[23:8] == `SWL_RA_VOL_HI;
	wire        a_nv_w     = addr_nxt_w[23:8] == `SWL_RA_NV_HI;
	wire  [2:0] a_idx_w    = (a_vol_w | a_nv_w) ? addr_index(addr_nxt_w[7:0]) : `SWL_IDX_NONE;
	wire        ra_vol_w   = addr_r[23:8] == `SWL_RA_VOL_HI;
	wire        ra_nv_w    = addr_r[23:8] == `SWL_RA_NV_HI;
	wire  [2:0] ra_idx_w   = (ra_vol_w | ra_nv_w) ? addr_index(addr_r[7:0]) : `SWL_IDX_NONE;

	// read source selection
	logic [2:0] rd_idx_r;
	logic       rd_nv_r;
	wire  swl_byte_t sr1_full_w = {sr1_r, write_enable_latch_o, write_in_progress_i};
	wire  swl_byte_t rd_vol_w = (rd_idx_r == `SWL_IDX_SR1) ? sr1_full_w :
	                            (rd_idx_r == `SWL_IDX_SR2) ? status_reg_two_i :
	                            (rd_idx_r == `SWL_IDX_CR1) ? config_reg_one_o :
	                            (rd_idx_r == `SWL_IDX_CR2) ? config_reg_two_o :
	                            (rd_idx_r == `SWL_IDX_CR4) ? config_reg_four_o :
	                            (rd_idx_r == `SWL_IDX_CR5) ? config_reg_five_o : 8'h00;
	wire  swl_byte_t rd_nvv_w = (rd_idx_r == `SWL_IDX_SR1) ? nv_status_reg_one_i :
	                            (rd_idx_r == `SWL_IDX_SR2) ? status_reg_two_i :
	                            (rd_idx_r == `SWL_IDX_CR1) ? nv_config_reg_one_i :
	                            (rd_idx_r == `SWL_IDX_CR2) ? nv_config_reg_two_i :
	                            (rd_idx_r == `SWL_IDX_CR4) ? nv_config_reg_four_i :
	                            (rd_idx_r == `SWL_IDX_CR5) ? nv_config_reg_five_i : 8'h00;
	wire  swl_byte_t rd_byte_w = rd_nv_r ? rd_nvv_w : rd_vol_w;
	wire        to_data_w  = (rlc_w == 2'h0);
	// first bit of each byte comes from the live register, not a stale copy
	wire  swl_byte_t osrc_w    = (obitcnt_r == 4'h0) ? rd_byte_w : out_sr_r;
	wire  swl_byte_t sr1_rld_w = merge(SR1_DEF, nv_status_reg_one_i, `SWL_SR1_NV_MASK);
	wire  swl_byte_t sr1_wr_w  = merge(sr1_full_w, wdata_r, `SWL_SR1_WMASK);

	// command completion at chip select rise
	wire        clean8_w   = cs_rise_w & op_done_r & ~extra_r & (state_r == SWL_SKIP);
	wire        wel_w      = write_enable_latch_o;
	wire        protect_w  = sr1_r[`SWL_SR1_WRITE_DISABLE] & ~write_protect_n_i;
	wire        is_status_write_cmd_w  = op_done_r & (opcode_r == `SWL_OP_STATUS_WRITE);
	wire        is_generic_reg_write_cmd_w  = op_done_r & (opcode_r == `SWL_OP_GENERIC_WRITE);
	wire        reg_wr_w   = cs_rise_w & wdata_ok_r & wel_w & ~protect_w;
	wire        do_status_write_cmd_w  = reg_wr_w & is_status_write_cmd_w;
	wire        do_generic_reg_write_cmd_w  = reg_wr_w & is_generic_reg_write_cmd_w & (ra_idx_w != `SWL_IDX_NONE)
	                       & (ra_idx_w != `SWL_IDX_SR2);
	wire  [2:0] wr_idx_w   = do_status_write_cmd_w ? `SWL_IDX_SR1 : ra_idx_w;
	wire        wr_vol_w   = do_status_write_cmd_w | do_generic_reg_write_cmd_w;
	wire        wr_nv_w    = do_status_write_cmd_w | (do_generic_reg_write_cmd_w & ra_nv_w);
	wire        set_wel_w  = clean8_w & (opcode_r == `SWL_OP_SET_WRITE_LATCH);
	wire        clr_wel_w  = clean8_w & (opcode_r == `SWL_OP_CLEAR_WRITE_LATCH) & ~write_in_progress_i;
	wire        end_wr_w   = cs_rise_w & (is_status_write_cmd_w | is_generic_reg_write_cmd_w);
	wire        do_dpd_w   = clean8_w & (opcode_r == `SWL_OP_DEEP_POWERDOWN);
	wire        do_hbn_w   = clean8_w & (opcode_r == `SWL_OP_HIBERNATE);
	wire        do_arm_w   = clean8_w & (opcode_r == `SWL_OP_RESET_ARM);
	wire        do_rst_w   = clean8_w & (opcode_r == `SWL_OP_RESET) & armed_r;
	wire        reload_w   = ~resetn_i | soft_reset_o;

	// serial frame sequencing
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || !cs_act_w) begin
			state_r    <= cs_act_w ? SWL_OPC : SWL_IDLE;
			bitcnt_r   <= 4'h0;
			abytes_r   <= 2'h0;
			op_done_r  <= resetn_i ? op_done_r & ~cs_rise_w & ~lvl_w[5] : 1'b0;
			extra_r    <= 1'b0;
			wdata_ok_r <= resetn_i ? wdata_ok_r & ~cs_rise_w & ~lvl_w[5] : 1'b0;
		end else if (state_r == SWL_IDLE) begin
			state_r    <= SWL_OPC;
			op_done_r  <= 1'b0;
			wdata_ok_r <= 1'b0;
		end else if (sck_rise_w) begin
			in_sr_r  <= in_nxt_w;
			bitcnt_r <= byte_w ? 4'h0 : bitcnt_r + nb_w;
			case (state_r)
				SWL_OPC: begin
					if (byte_w) begin
						opcode_r  <= in_nxt_w;
						op_done_r <= 1'b1;
						dcnt_r    <= rlc_w;
						rd_idx_r  <= fix_idx_w;
						rd_nv_r   <= 1'b0;
						if (d_fix_rd)
							state_r <= to_data_w ? SWL_RDATA : SWL_DUMMY;
						else if (d_gen)
							state_r <= SWL_ADDR;
						else if (in_nxt_w == `SWL_OP_STATUS_WRITE)
							state_r <= SWL_WDATA;
						else
							state_r <= SWL_SKIP;
					end
				end
				SWL_ADDR: begin
					if (byte_w) begin
						addr_r   <= addr_nxt_w;
						abytes_r <= abytes_r + 2'h1;
						if (abytes_r == `SWL_ADDR_BYTES - 2'h1) begin
							rd_idx_r <= a_idx_w;
							rd_nv_r  <= a_nv_w;
							if (opcode_r == `SWL_OP_GENERIC_WRITE)
								state_r <= SWL_WDATA;
							else
								state_r <= to_data_w ? SWL_RDATA : SWL_DUMMY;
						end
					end
				end
				SWL_DUMMY: begin
					bitcnt_r <= 4'h0;
					dcnt_r   <= dcnt_r - 2'h1;
					if (dcnt_r == 2'h1)
						state_r <= SWL_RDATA;
				end
				SWL_WDATA: begin
					if (byte_w) begin
						wdata_r    <= in_nxt_w;
						wdata_ok_r <= 1'b1;
						state_r    <= SWL_SKIP;
					end
				end
				SWL_SKIP: extra_r <= 1'b1;
				default: state_r <= state_r;
			endcase
		end
	end

	// read data out, changed on the falling clock edge
	always_ff @(posedge mclk_i) begin
		if (!resetn_i || !cs_act_w || state_r != SWL_RDATA) begin
			io_o      <= 4'h0;
			io_oe_o   <= 4'h0;
			obitcnt_r <= 4'h0;
			out_sr_r  <= rd_byte_w;
		end else begin
			if (sck_fall_w) begin
				obitcnt_r <= ((obitcnt_r + nb_w) == 4'h8) ? 4'h0 : obitcnt_r + nb_w;
				case (lane_mode_i)
					`SWL_LANES_TWO: begin
						io_o    <= {2'b00, osrc_w[7:6]};
						io_oe_o <= 4'h3;
						out_sr_r <= {osrc_w[5:0], 2'b00};
					end
					`SWL_LANES_FOUR: begin
						io_o    <= osrc_w[7:4];
						io_oe_o <= 4'hF;
						out_sr_r <= {osrc_w[3:0], 4'h0};
					end
					default: begin
						io_o    <= {2'b00, osrc_w[7], 1'b0};
						io_oe_o <= 4'h2;
						out_sr_r <= {osrc_w[6:0], 1'b0};
					end
				endcase
			end
		end
	end

	// write enable latch
	always_ff @(posedge mclk_i) begin
		if (reload_w)
			write_enable_latch_o <= SR1_DEF[`SWL_SR1_WEL];
		else if (set_wel_w)
			write_enable_latch_o <= 1'b1;
		else if (clr_wel_w || end_wr_w)
			write_enable_latch_o <= 1'b0;
	end

	// volatile register copies
	always_ff @(posedge mclk_i) begin
		if (reload_w) begin
			sr1_r             <= sr1_rld_w[7:2];
			config_reg_one_o  <= nv_config_reg_one_i;
			config_reg_two_o  <= nv_config_reg_two_i;
			config_reg_four_o <= nv_config_reg_four_i;
			config_reg_five_o <= nv_config_reg_five_i;
		end else if (wr_vol_w) begin
			case (wr_idx_w)
				`SWL_IDX_SR1: sr1_r <= sr1_wr_w[7:2];
				`SWL_IDX_CR1: config_reg_one_o  <= merge(config_reg_one_o, wdata_r, `SWL_CR1_WMASK);
				`SWL_IDX_CR2: config_reg_two_o  <= merge(config_reg_two_o, wdata_r, `SWL_CR2_WMASK);
				`SWL_IDX_CR4: config_reg_four_o <= merge(config_reg_four_o, wdata_r, `SWL_CR4_WMASK);
				`SWL_IDX_CR5: config_reg_five_o <= merge(config_reg_five_o, wdata_r, `SWL_CR5_WMASK);
				default: sr1_r <= sr1_r;
			endcase
		end
	end

	// nonvolatile program request and one-cycle command pulses
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			nv_write_o        <= 1'b0;
			nv_index_o        <= `SWL_IDX_NONE;
			nv_data_o         <= 8'h00;
			mem_write_grant_o <= 1'b0;
			deep_powerdown_o  <= 1'b0;
			hibernate_o       <= 1'b0;
			reset_arm_o       <= 1'b0;
			soft_reset_o      <= 1'b0;
			armed_r           <= 1'b0;
			status_reg_one_o  <= 8'h00;
		end else begin
			nv_write_o        <= wr_nv_w;
			nv_index_o        <= wr_nv_w ? wr_idx_w : nv_index_o;
			nv_data_o         <= wr_nv_w ? wdata_r : nv_data_o;
			mem_write_grant_o <= sck_rise_w & (state_r == SWL_OPC) & byte_w & d_memwr & wel_w;
			deep_powerdown_o  <= do_dpd_w;
			hibernate_o       <= do_hbn_w;
			reset_arm_o       <= do_arm_w;
			soft_reset_o      <= do_rst_w;
			armed_r           <= cs_rise_w ? do_arm_w : armed_r;
			status_reg_one_o  <= sr1_full_w;
		end
	end

endmodule // swl_cmd

`default_nettype wire

// ---- hdl/swl_sync.sv ----
// three-stage input synchroniser with agreed-level edge pulses
`timescale 1ns/1ps
`default_nettype none

module swl_sync #(
	parameter int W    = 6,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	wire  [W-1:0] agree_w = ~(s2_r ^ s3_r);
	wire  [W-1:0] lvl_nxt = (agree_w & s3_r) | (~agree_w & level_o);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			s1_r    <= INIT;
			s2_r    <= INIT;
			s3_r    <= INIT;
			level_o <= INIT;
			rise_o  <= '0;
			fall_o  <= '0;
		end else begin
			s1_r    <= async_i;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_o <= lvl_nxt;
			rise_o  <= lvl_nxt & ~level_o;
			fall_o  <= ~lvl_nxt & level_o;
		end
	end

endmodule // swl_sync

`default_nettype wire
